// ==== rtl/adc_readout_map.vh ====
// Constants for the dual converter readout block: timing, codes, layout.
// Assumes a 40 MHz system clock; all cycle counts are derived from it.
`ifndef ADC_READOUT_MAP_VH
`define ADC_READOUT_MAP_VH

`define CLK_PERIOD_NS     25
`define HOLD_MIN_NS       15
`define HOLD_MIN_CYCLES   ((`HOLD_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CONV_TIME_NS      1750
`define CONV_CYCLES       (`CONV_TIME_NS / `CLK_PERIOD_NS)
`define ACQ_TIME_NS       250
`define ACQ_CYCLES        (`ACQ_TIME_NS / `CLK_PERIOD_NS)
`define CNT_W             7

`define VALID_BIT         15
`define CHAN_MSB          14
`define CHAN_LSB          12
`define RESULT_MSB        11
`define RESULT_LSB        0

`define PAIR_A            2'h0
`define PAIR_B            2'h1
`define PAIR_C            2'h2
`define CHAN_COUNT        3'h6
`define SEL_NEXT_A        3'h6
`define SEL_NEXT_B        3'h7

`define WORD_RESET        16'h0000
`define VALID_RESET       6'h00

`endif

// ==== rtl/result_store.v ====
// Six-word result memory, one word per input channel.
// Assumes one write and one read address per clock; read data is registered.
`timescale 1ns/10ps
module result_store (
	input  wire        clock,
	input  wire        writeEn,
	input  wire [2:0]  writeAddr,
	input  wire [11:0] writeData,
	input  wire [2:0]  readAddr,
	output reg  [11:0] readData_q
);
	reg [11:0] mem [0:5];

	always @(posedge clock) begin
		if (writeEn) begin
			mem[writeAddr] <= writeData;
		end
		readData_q <= mem[readAddr];
	end
endmodule

// ==== rtl/adc_readout.v ====
// Conversion sequencing and parallel readout of a dual six-channel converter.
// Assumes host pins are synchronous to clock; the two converter cores
// present their 12-bit results when the conversion time has elapsed.
`timescale 1ns/10ps
`include "adc_readout_map.vh"

module adc_readout (
	input  wire        clock,
	input  wire        rst_n,
	input  wire        pairASampleFreezeN,
	input  wire        pairBSampleFreezeN,
	input  wire        pairCSampleFreezeN,
	input  wire        readStrobeN,
	input  wire        chipSelectN,
	input  wire        byteSplit,
	input  wire        channelModeSel2,
	input  wire        channelModeSel1,
	input  wire        channelModeSel0,
	input  wire [11:0] converter0Result,
	input  wire [11:0] converter1Result,
	output wire        pairAHold,
	output wire        pairBHold,
	output wire        pairCHold,
	output wire        busyN,
	output wire [15:0] dataOut,
	output wire        dataOutEn
);
	localparam IDLE = 3'h0;
	localparam CONV = 3'h1;
	localparam WRLO = 3'h2;
	localparam WRHI = 3'h3;
	localparam ACQ  = 3'h4;

	reg  [2:0]        state_q;
	reg  [2:0]        state_d;
	reg  [`CNT_W-1:0] count_q;
	reg  [`CNT_W-1:0] count_d;
	reg  [1:0]        pair_q;
	reg  [1:0]        pair_d;
	reg  [2:0]        holdPrev_q;
	reg  [2:0]        freeze_q;
	reg  [5:0]        valid_q;
	reg  [5:0]        validClr;
	reg  [5:0]        validSet;
	reg  [2:0]        nextPtr_q;
	reg  [2:0]        chanDly_q;
	reg               validDly_q;
	reg               bytePhase_q;
	reg               reading_q;
	reg  [15:0]       pinWord_q;
	reg  [11:0]       hiResult_q;
	reg               writeEn;
	reg  [2:0]        writeAddr;
	reg  [11:0]       writeData;
	wire [2:0]        holdNow;
	wire [2:0]        holdFall;
	wire [2:0]        modeSel;
	wire [2:0]        readChan;
	wire              reading;
	wire              readEnd;
	wire [11:0]       memData;
	wire [15:0]       word;

	function [2:0] wrapInc;
		input [2:0] v;
		begin
			if (v == `CHAN_COUNT - 3'h1) begin
				wrapInc = 3'h0;
			end else begin
				wrapInc = v + 3'h1;
			end
		end
	endfunction

	assign holdNow  = {pairCSampleFreezeN, pairBSampleFreezeN,
		pairASampleFreezeN};
	assign holdFall = holdPrev_q & ~holdNow;
	assign modeSel  = {channelModeSel2, channelModeSel1, channelModeSel0};
	assign readChan = (modeSel == `SEL_NEXT_A || modeSel == `SEL_NEXT_B) ?
		nextPtr_q : modeSel;
	assign reading  = ~readStrobeN & ~chipSelectN;
	assign readEnd  = reading_q & ~reading;
	assign pairAHold = freeze_q[0];
	assign pairBHold = freeze_q[1];
	assign pairCHold = freeze_q[2];
	assign busyN     = ~(state_q == CONV || state_q == WRLO ||
		state_q == WRHI);
	assign dataOut   = pinWord_q;
	assign dataOutEn = reading;
	assign word = {validDly_q, chanDly_q, memData};

	result_store store (
		.clock      (clock),
		.writeEn    (writeEn),
		.writeAddr  (writeAddr),
		.writeData  (writeData),
		.readAddr   (readChan),
		.readData_q (memData)
	);

	always @* begin
		state_d   = state_q;
		count_d   = count_q;
		pair_d    = pair_q;
		writeEn   = 1'b0;
		writeAddr = {pair_q, 1'b0};
		writeData = converter0Result;
		validSet  = 6'h00;
		case (state_q)
			IDLE: begin
				count_d = {`CNT_W{1'b0}};
				if (freeze_q[0]) begin
					pair_d  = `PAIR_A;
					state_d = CONV;
				end else if (freeze_q[1]) begin
					pair_d  = `PAIR_B;
					state_d = CONV;
				end else if (freeze_q[2]) begin
					pair_d  = `PAIR_C;
					state_d = CONV;
				end
			end
			CONV: begin
				count_d = count_q + 1'b1;
				if (count_q == `CONV_CYCLES - 1) begin
					state_d = WRLO;
				end
			end
			WRLO: begin
				writeEn  = 1'b1;
				validSet = 6'h01 << {pair_q, 1'b0};
				state_d  = WRHI;
			end
			WRHI: begin
				writeEn   = 1'b1;
				writeAddr = {pair_q, 1'b1};
				writeData = hiResult_q;
				validSet  = 6'h01 << {pair_q, 1'b1};
				count_d   = {`CNT_W{1'b0}};
				state_d   = ACQ;
			end
			ACQ: begin
				count_d = count_q + 1'b1;
				if (count_q == `ACQ_CYCLES - 1) begin
					state_d = IDLE;
				end
			end
			default: begin
				state_d = IDLE;
			end
		endcase
	end

	always @* begin
		validClr = 6'h00;
		if (readEnd && (!byteSplit || bytePhase_q)) begin
			validClr = 6'h01 << readChan;
		end
	end

	always @(posedge clock) begin
		if (!rst_n) begin
			state_q     <= IDLE;
			count_q     <= {`CNT_W{1'b0}};
			pair_q      <= `PAIR_A;
			holdPrev_q  <= 3'h7;
			freeze_q    <= 3'h0;
			valid_q     <= `VALID_RESET;
			nextPtr_q   <= 3'h0;
			chanDly_q   <= 3'h0;
			validDly_q  <= 1'b0;
			bytePhase_q <= 1'b0;
			reading_q   <= 1'b0;
			pinWord_q   <= `WORD_RESET;
			hiResult_q  <= 12'h000;
		end else begin
			state_q    <= state_d;
			count_q    <= count_d;
			pair_q     <= pair_d;
			holdPrev_q <= holdNow;
			reading_q  <= reading;
			freeze_q <= holdFall |
				(freeze_q & ~((state_q == ACQ) ? (3'h1 << pair_q) : 3'h0));
			if (state_q == WRLO) begin
				hiResult_q <= converter1Result;
			end
			valid_q <= (valid_q & ~validClr) | validSet;
			chanDly_q  <= readChan;
			validDly_q <= valid_q[readChan];
			if (readEnd) begin
				bytePhase_q <= byteSplit & ~bytePhase_q;
				if ((!byteSplit || bytePhase_q) &&
					(modeSel == `SEL_NEXT_A || modeSel == `SEL_NEXT_B)) begin
					nextPtr_q <= wrapInc(nextPtr_q);
				end
			end
			if (!reading) begin
				if (byteSplit) begin
					pinWord_q <= bytePhase_q ? {8'h00, word[7:0]} :
						{8'h00, word[15:8]};
				end else begin
					pinWord_q <= word;
				end
			end
		end
	end
endmodule

// ==== sim/adc_readout_assertions.sv ====
// Timing checks on the readout block's ports.
// Assumes one clock; bound to every adc_readout instance.
`timescale 1ns/10ps
module adc_readout_assertions (
	input wire        clock,
	input wire        rst_n,
	input wire        pairASampleFreezeN,
	input wire        pairBSampleFreezeN,
	input wire        readStrobeN,
	input wire        chipSelectN,
	input wire        byteSplit,
	input wire        pairAHold,
	input wire        pairBHold,
	input wire        busyN,
	input wire [15:0] dataOut,
	input wire        dataOutEn
);
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_n);
	a_out_enable: assert property (
		dataOutEn == (!readStrobeN && !chipSelectN)) else $error("enable");
	a_hold_a_freeze: assert property (
		$fell(pairASampleFreezeN) |=> pairAHold) else $error("hold a");
	a_hold_b_freeze: assert property (
		$fell(pairBSampleFreezeN) |=> pairBHold) else $error("hold b");
	a_hold_stands: assert property (
		$rose(pairAHold) |-> pairAHold[*8]) else $error("hold short");
	a_busy_span: assert property (
		$fell(busyN) |-> ##71 !busyN ##1 busyN) else $error("busy span");
	a_reset_idle: assert property (disable iff (1'b0)
		!rst_n |=> dataOut == 16'h0000 && busyN) else $error("reset");
	a_word_frozen: assert property (
		dataOutEn && $past(dataOutEn) |-> $stable(dataOut)) else $error("frozen");
	a_byte_upper: assert property (
		byteSplit[*4] |-> dataOut[15:8] == 8'h00) else $error("byte");
endmodule
bind adc_readout adc_readout_assertions chk (.clock, .rst_n,
	.pairASampleFreezeN, .pairBSampleFreezeN, .readStrobeN, .chipSelectN,
	.byteSplit, .pairAHold, .pairBHold, .busyN, .dataOut, .dataOutEn);

// ==== sim/converter_model.sv ====
// Converter core model: freezes a pair's inputs and presents them as results.
// Assumes pairs are converted lowest first while the block is busy.
`timescale 1ns/10ps
module converter_model (
	input  wire        clock,
	input  wire        pairAHold,
	input  wire        pairBHold,
	input  wire        pairCHold,
	input  wire        busyN,
	input  wire [71:0] samples,
	output wire [11:0] converter0Result,
	output wire [11:0] converter1Result
);
	reg [23:0] held [0:2];
	reg [1:0]  cur = 2'h0;
	reg [2:0]  done = 3'h0;
	reg [2:0]  holdQ = 3'h0;
	reg        busyQ = 1'b1;
	integer    k;
	wire [2:0] holds = {pairCHold, pairBHold, pairAHold};
	wire [2:0] wait3 = holds & ~done;
	wire [2:0] pick = wait3 & (~wait3 + 3'h1);
	always @(posedge clock) begin
		busyQ <= busyN;
		holdQ <= holds;
		for (k = 0; k < 3; k = k + 1)
			if (holds[k] && !holdQ[k])
				held[k] <= samples[k*24 +: 24];
		done <= (done | ((busyQ && !busyN) ? pick : 3'h0)) & holds;
		if (busyQ && !busyN)
			cur <= pick[2] ? 2'h2 : (pick[1] ? 2'h1 : 2'h0);
	end
	// Outside a conversion the outputs carry no valid result.
	assign {converter1Result, converter0Result} = busyN ? ~held[cur] : held[cur];
endmodule

// ==== sim/test_adc_readout.sv ====
// Self-checking bench for adc_readout with a converter core model.
// Assumes the design, its header, checker and model are compiled first.
`timescale 1ns/10ps
`define CHK(a,b) begin compares=compares+1; if ((a)!==(b)) begin \
failures=failures+1; $display("BAD %0t %h %h", $time, a, b); end end
module test_adc_readout;
	reg clock = 0, rst_n = 0, rdN = 1, csN = 1, byteSplit = 0;
	reg [2:0] freezeN = 3'h7, sel = 3'h0;
	reg [71:0] samp;
	reg [15:0] got, e;
	integer seed = 61458, failures = 0, compares = 0, i;
	wire [11:0] r0, r1;
	wire hA, hB, hC, busyN, dataOutEn;
	wire [15:0] dataOut;
	adc_readout DUT (.clock, .rst_n, .pairASampleFreezeN(freezeN[0]),
		.pairBSampleFreezeN(freezeN[1]), .pairCSampleFreezeN(freezeN[2]),
		.readStrobeN(rdN), .chipSelectN(csN), .byteSplit,
		.channelModeSel2(sel[2]), .channelModeSel1(sel[1]),
		.channelModeSel0(sel[0]), .converter0Result(r0),
		.converter1Result(r1), .pairAHold(hA), .pairBHold(hB),
		.pairCHold(hC), .busyN, .dataOut, .dataOutEn);
	converter_model cores (.clock, .pairAHold(hA), .pairBHold(hB),
		.pairCHold(hC), .busyN, .samples(samp), .converter0Result(r0),
		.converter1Result(r1));
	always #12.5 clock = ~clock;
	task cyc(input integer n); repeat (n) @(posedge clock); endtask
	function [15:0] expWord(input [2:0] ch);
		expWord = {1'b1, ch, samp[(ch>>1)*24 + (ch[0] ? 12 : 0) +: 12]};
	endfunction
	task hold(input [2:0] m); begin
		@(posedge clock); freezeN <= ~m; cyc(2); freezeN <= 3'h7; cyc(90);
	end endtask
	task rd(input [2:0] ch); begin
		@(posedge clock); sel <= ch; cyc(3); rdN <= 0; csN <= 0; cyc(2);
		`CHK(dataOutEn, 1'b1)
		got = dataOut;
		rdN <= 1; csN <= 1; cyc(4);
		`CHK(dataOutEn, 1'b0)
	end endtask
	task complete_run; begin
		$display("compares %0d failures %0d", compares, failures);
		if (failures == 0 && compares > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	end endtask
	initial begin
		samp = {$random(seed), $random(seed), $random(seed)};
		cyc(20); rst_n <= 1; cyc(2);
		@(posedge clock); freezeN <= 3'h0; cyc(2); freezeN <= 3'h7; cyc(2); #1;
		`CHK(busyN, 1'b0)
		`CHK({hC, hB, hA}, 3'h7)
		cyc(260);
		`CHK(busyN, 1'b1)
		for (i = 0; i < 6; i = i + 1) begin
			rd(i); `CHK(got, expWord(i))
			rd(i); `CHK(got[15], 1'b0)
		end
		$display("word reads done");
		samp = {$random(seed), $random(seed), $random(seed)};
		@(posedge clock); byteSplit <= 1; hold(3'h2); e = expWord(3'h3);
		rd(3); `CHK(got, {8'h00, e[15:8]})
		rd(3); `CHK(got, {8'h00, e[7:0]})
		@(posedge clock); byteSplit <= 0;
		$display("byte reads done");
		@(posedge clock); freezeN <= 3'h6; cyc(10); rst_n <= 0; cyc(2);
		freezeN <= 3'h7; rst_n <= 1; #1;
		`CHK({busyN, hA, dataOut}, 18'h20000)
		rd(0); `CHK(got[15], 1'b0)
		$display("reset test done");
		hold(3'h1);
		rd(3'h6); `CHK(got, expWord(3'h0))
		rd(3'h6); `CHK(got, expWord(3'h1))
		$display("next mode done");
		complete_run;
	end
	initial begin
		repeat (3000) @(posedge clock);
		failures = failures + 1;
		complete_run;
	end
endmodule
